/* rtl/pfmux_top.sv */
`timescale 1ns/1ps
module pfmux_top
    import pfmux_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PFMUX_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // peripheral outputs, four alternates per pad
    input wire logic [PFMUX_NUM_PADS*PFMUX_NUM_ALT-1:0] alt_out_i,
    input wire logic [PFMUX_NUM_PADS*PFMUX_NUM_ALT-1:0] alt_oe_i,
    // package pads
    input wire logic [PFMUX_NUM_PADS-1:0] pad_in_i,
    output logic [PFMUX_NUM_PADS-1:0] pad_out_o,
    output logic [PFMUX_NUM_PADS-1:0] pad_oe_o,
    output logic [PFMUX_NUM_PADS-1:0] pad_slew_fast_o,
    // peripheral inputs
    output logic [PFMUX_NUM_PADS-1:0] pad_in_gpio_o,
    output logic [PFMUX_NUM_PADS-1:0] pad_in_only_o,
    output logic [PFMUX_NUM_SEL_IN-1:0] sel_in_o
);
    // per input source tables for the shared inputs: candidate c of input k
    // sits on pad k*16+c, a fixed wiring choice of this build
    logic [1:0] alt_func_select [PFMUX_NUM_PADS];
    logic input_buffer_enable [PFMUX_NUM_PADS];
    logic slew_rate_control [PFMUX_NUM_PADS];
    logic [PFMUX_SRC_W-1:0] pad_source_field [PFMUX_NUM_SEL_IN];
    logic [PFMUX_NUM_PADS-1:0] next_pad_out;
    logic [PFMUX_NUM_PADS-1:0] next_pad_oe;
    logic [PFMUX_NUM_PADS-1:0] next_in_only;
    logic [PFMUX_NUM_SEL_IN-1:0] next_sel_in;
    logic [31:0] next_rdata;
    pfmux_bus_state_t bus_state;
    logic [PFMUX_NUM_ALT-1:0] alt_changed_count;
    logic [15:0] cfg_write_count;

    // pad index from a port number and bit position
    function automatic logic [PFMUX_PAD_IDX_W-1:0] pad_index(input logic [2:0] port, input logic [3:0] bitpos);
        pad_index = {port, bitpos};
    endfunction

    function automatic logic in_range(input logic [PFMUX_ADDR_W-1:0] adr, input logic [PFMUX_ADDR_W-1:0] base,
                                      input int count);
        logic [PFMUX_ADDR_W-1:0] off;
        off = adr - base;
        in_range = (adr >= base) && (int'(off[PFMUX_ADDR_W-1:2]) < count);
    endfunction

    function automatic logic [PFMUX_ADDR_W-1:0] word_of(input logic [PFMUX_ADDR_W-1:0] adr,
                                                       input logic [PFMUX_ADDR_W-1:0] base);
        logic [PFMUX_ADDR_W-1:0] off;
        off = adr - base;
        word_of = {2'b00, off[PFMUX_ADDR_W-1:2]};
    endfunction

    wire bus_req = wb_cyc_i && wb_stb_i && (bus_state == PFMUX_BUS_IDLE);
    wire bus_wr = bus_req && wb_we_i;
    wire hit_cfg = in_range(wb_adr_i, PFMUX_CFG_BASE, PFMUX_NUM_PADS);
    wire hit_psm = in_range(wb_adr_i, PFMUX_PSM_BASE, PFMUX_NUM_SEL_IN);
    wire hit_pin = in_range(wb_adr_i, PFMUX_PADIN_BASE, PFMUX_NUM_PORTS);
    wire [PFMUX_ADDR_W-1:0] cfg_word = word_of(wb_adr_i, PFMUX_CFG_BASE);
    wire [PFMUX_ADDR_W-1:0] psm_word = word_of(wb_adr_i, PFMUX_PSM_BASE);
    wire [PFMUX_ADDR_W-1:0] pin_word = word_of(wb_adr_i, PFMUX_PADIN_BASE);
    wire [PFMUX_PAD_IDX_W-1:0] cfg_idx = pad_index(cfg_word[6:4], cfg_word[3:0]);

    // one-cycle ack; the bus idles a cycle between accesses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state <= PFMUX_BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            case (bus_state)
                PFMUX_BUS_IDLE: begin
                    wb_ack_o <= bus_req;
                    if (bus_req) begin
                        bus_state <= PFMUX_BUS_ACK;
                    end
                end
                PFMUX_BUS_ACK: begin
                    wb_ack_o <= 1'b0;
                    bus_state <= PFMUX_BUS_IDLE;
                end
                default: begin
                    wb_ack_o <= 1'b0;
                    bus_state <= PFMUX_BUS_IDLE;
                end
            endcase
        end
    end

    // pad configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < PFMUX_NUM_PADS; p++) begin
                alt_func_select[p] <= PFMUX_ALT_RESET;
                input_buffer_enable[p] <= PFMUX_INBUF_RESET;
                slew_rate_control[p] <= PFMUX_SLEW_RESET;
            end
        end else if (bus_wr && hit_cfg) begin
            if (wb_sel_i[0]) begin
                alt_func_select[cfg_idx] <= wb_dat_i[PFMUX_ALT_LSB +: PFMUX_ALT_W];
                input_buffer_enable[cfg_idx] <= wb_dat_i[PFMUX_INBUF_BIT];
            end
            if (wb_sel_i[1]) begin
                slew_rate_control[cfg_idx] <= wb_dat_i[PFMUX_SLEW_BIT];
            end
        end
    end

    // input source select registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < PFMUX_NUM_SEL_IN; k++) begin
                pad_source_field[k] <= PFMUX_SRC_RESET;
            end
        end else if (bus_wr && hit_psm && wb_sel_i[0]) begin
            pad_source_field[psm_word[PFMUX_SEL_IN_W-1:0]] <= wb_dat_i[PFMUX_SRC_W-1:0];
        end
    end

    // write counter shown in the status word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_write_count <= 16'h0000;
        end else if (bus_wr && (hit_cfg || hit_psm)) begin
            cfg_write_count <= cfg_write_count + 16'h0001;
        end
    end

    // read mux; unmapped addresses read as zero and are still acked
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_cfg) begin
            next_rdata[PFMUX_ALT_LSB +: PFMUX_ALT_W] = alt_func_select[cfg_idx];
            next_rdata[PFMUX_INBUF_BIT] = input_buffer_enable[cfg_idx];
            next_rdata[PFMUX_SLEW_BIT] = slew_rate_control[cfg_idx];
        end else if (hit_psm) begin
            next_rdata[PFMUX_SRC_W-1:0] = pad_source_field[psm_word[PFMUX_SEL_IN_W-1:0]];
        end else if (hit_pin) begin
            next_rdata[PFMUX_PORT_WIDTH-1:0] = pad_in_i[pin_word[2:0]*PFMUX_PORT_WIDTH +: PFMUX_PORT_WIDTH];
        end else if (wb_adr_i == PFMUX_STATUS_ADDR) begin
            next_rdata[15:0] = cfg_write_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PFMUX_NUM_PADS; g++) begin : g_pad
            pfmux_pad_cell u_cell (
                .alt_func_select_i(alt_func_select[g]),
                .input_buffer_enable_i(input_buffer_enable[g]),
                .alt_out_i(alt_out_i[g*PFMUX_NUM_ALT +: PFMUX_NUM_ALT]),
                .alt_oe_i(alt_oe_i[g*PFMUX_NUM_ALT +: PFMUX_NUM_ALT]),
                .pad_in_i(pad_in_i[g]),
                .pad_out_o(next_pad_out[g]),
                .pad_oe_o(next_pad_oe[g]),
                .input_only_o(next_in_only[g])
            );
        end
    endgenerate

    // shared inputs: candidate pads chosen by the source field
    always_comb begin
        for (int k = 0; k < PFMUX_NUM_SEL_IN; k++) begin
            next_sel_in[k] = pad_in_i[k*PFMUX_NUM_SRC + int'(pad_source_field[k])];
        end
    end

    // registered pad and peripheral side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
            pad_slew_fast_o <= '0;
            pad_in_gpio_o <= '0;
            pad_in_only_o <= '0;
            sel_in_o <= '0;
        end else begin
            pad_out_o <= next_pad_out;
            pad_oe_o <= next_pad_oe;
            pad_in_gpio_o <= pad_in_i;
            pad_in_only_o <= next_in_only;
            sel_in_o <= next_sel_in;
            for (int p = 0; p < PFMUX_NUM_PADS; p++) begin
                // slow requested is always obeyed, on every pad alike
                pad_slew_fast_o[p] <= slew_rate_control[p];
            end
        end
    end

    // helper for checks: pads currently off the first alternate, low bits only
    always_comb begin
        alt_changed_count = '0;
        for (int p = 0; p < PFMUX_NUM_ALT; p++) begin
            alt_changed_count[p] = (alt_func_select[p] != PFMUX_ALT_RESET);
        end
    end

    sequence s_rst_release;
        rst_i ##1 !rst_i;
    endsequence

    chk_reset_first_alt: assert property (@(posedge clk_i) s_rst_release |-> alt_changed_count == '0)
        else $error("pad not on first alternate after reset");
    chk_reset_pads_out: assert property (@(posedge clk_i) s_rst_release |-> pad_oe_o == '0 && pad_out_o == '0)
        else $error("pad drive not cleared by reset");
    // the first edge after reset still shows reset outputs, so the alternate, general-input and source-select checks skip it
    chk_alt_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> pad_out_o[45] == $past(alt_out_i[PFMUX_NUM_ALT*45 + int'(alt_func_select[45])]))
        else $error("pad 45 output not from selected alternate");
    chk_alt_oe: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> pad_oe_o[30] == $past(alt_oe_i[PFMUX_NUM_ALT*30 + int'(alt_func_select[30])]))
        else $error("pad 30 enable not from selected alternate");
    chk_inbuf_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(input_buffer_enable[0]) |-> !pad_in_only_o[0])
        else $error("input-only function saw pad with buffer off");
    chk_inbuf_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(input_buffer_enable[3]) |-> pad_in_only_o[3] == $past(pad_in_i[3]))
        else $error("input-only function missed pad with buffer on");
    chk_gpio_fanout: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> pad_in_gpio_o == $past(pad_in_i))
        else $error("pad input not routed to general input");
    chk_src_select: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> sel_in_o[0] == $past(pad_in_i[int'(pad_source_field[0])]))
        else $error("shared input not from selected pad");
    chk_slew_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        pad_slew_fast_o[40] == $past(slew_rate_control[40]))
        else $error("slew output does not follow register");
    chk_slew_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && hit_cfg && cfg_idx == 7'h28 && wb_sel_i[1])
        |-> ##2 pad_slew_fast_o[40] == $past(wb_dat_i[PFMUX_SLEW_BIT], 2))
        else $error("slow slew write not honoured");
    chk_index_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && wb_adr_i == 12'h078 && wb_sel_i[0]) |=> alt_func_select[30] == $past(wb_dat_i[1:0]))
        else $error("port b bit fourteen not at index thirty");
endmodule

/* rtl/pfmux_pkg.sv */
package pfmux_pkg;
    // pad array shape: ports of sixteen pads each
    localparam int PFMUX_NUM_PORTS = 8;
    localparam int PFMUX_PORT_WIDTH = 16;
    localparam int PFMUX_NUM_PADS = PFMUX_NUM_PORTS * PFMUX_PORT_WIDTH;
    localparam int PFMUX_PAD_IDX_W = 7;
    localparam int PFMUX_NUM_ALT = 4;

    // shared peripheral inputs that need a pad choice
    localparam int PFMUX_NUM_SEL_IN = 8;
    localparam int PFMUX_SEL_IN_W = 3;
    localparam int PFMUX_SRC_W = 4;
    localparam int PFMUX_NUM_SRC = 16;

    // register map (byte addresses)
    localparam logic [11:0] PFMUX_CFG_BASE = 12'h000;
    localparam logic [11:0] PFMUX_PSM_BASE = 12'h200;
    localparam logic [11:0] PFMUX_STATUS_ADDR = 12'h300;
    localparam logic [11:0] PFMUX_PADIN_BASE = 12'h320;
    localparam int PFMUX_ADDR_W = 12;

    // pad config register fields
    localparam int PFMUX_ALT_LSB = 0;
    localparam int PFMUX_ALT_W = 2;
    localparam int PFMUX_INBUF_BIT = 4;
    localparam int PFMUX_SLEW_BIT = 8;
    localparam logic [9:0] PFMUX_CFG_MASK = 10'h113;

    // reset values
    localparam logic [1:0] PFMUX_ALT_RESET = 2'h0;
    localparam logic PFMUX_INBUF_RESET = 1'b0;
    localparam logic PFMUX_SLEW_RESET = 1'b0;
    localparam logic [3:0] PFMUX_SRC_RESET = 4'h0;

    typedef enum logic [1:0] {
        PFMUX_ALT_FIRST = 2'b00,
        PFMUX_ALT_SECOND = 2'b01,
        PFMUX_ALT_THIRD = 2'b10,
        PFMUX_ALT_FOURTH = 2'b11
    } pfmux_alt_t;

    typedef enum logic [1:0] {
        PFMUX_BUS_IDLE = 2'b00,
        PFMUX_BUS_ACK = 2'b01
    } pfmux_bus_state_t;
endpackage

/* rtl/pfmux_pad_cell.sv */
`timescale 1ns/1ps
module pfmux_pad_cell
    import pfmux_pkg::*;
(
    // configuration
    input wire logic [1:0] alt_func_select_i,
    input wire logic input_buffer_enable_i,
    // peripheral output side
    input wire logic [PFMUX_NUM_ALT-1:0] alt_out_i,
    input wire logic [PFMUX_NUM_ALT-1:0] alt_oe_i,
    // pad side
    input wire logic pad_in_i,
    output logic pad_out_o,
    output logic pad_oe_o,
    output logic input_only_o
);
    always_comb begin
        case (pfmux_alt_t'(alt_func_select_i))
            PFMUX_ALT_FIRST: begin
                pad_out_o = alt_out_i[0];
                pad_oe_o = alt_oe_i[0];
            end
            PFMUX_ALT_SECOND: begin
                pad_out_o = alt_out_i[1];
                pad_oe_o = alt_oe_i[1];
            end
            PFMUX_ALT_THIRD: begin
                pad_out_o = alt_out_i[2];
                pad_oe_o = alt_oe_i[2];
            end
            PFMUX_ALT_FOURTH: begin
                pad_out_o = alt_out_i[3];
                pad_oe_o = alt_oe_i[3];
            end
            default: begin
                pad_out_o = alt_out_i[0];
                pad_oe_o = alt_oe_i[0];
            end
        endcase
    end

    // gated only by the buffer enable; the alternate field plays no part
    assign input_only_o = pad_in_i & input_buffer_enable_i;
endmodule

/* verif/pfmux_periph_model.sv */
`timescale 1ns/1ps
module pfmux_periph_model
    import pfmux_pkg::*;
(
    // clock
    input wire logic clk_i,
    // bench control
    input wire logic alt_inv_i,
    input wire logic [PFMUX_NUM_PADS-1:0] pad_level_i,
    // toward the mux
    output logic [PFMUX_NUM_PADS*PFMUX_NUM_ALT-1:0] alt_out_o,
    output logic [PFMUX_NUM_PADS*PFMUX_NUM_ALT-1:0] alt_oe_o,
    output logic [PFMUX_NUM_PADS-1:0] pad_o
);
    // every alternate gets its own out/oe pair, so a wrong select shows at the pad
    always_comb begin
        for (int i = 0; i < PFMUX_NUM_PADS*PFMUX_NUM_ALT; i++) begin
            alt_out_o[i] = i[0] ^ alt_inv_i;
            alt_oe_o[i] = i[1] ^ alt_inv_i;
        end
    end

    // the pad level arrives one clock late, like an input synchroniser
    initial pad_o = '0;
    always @(posedge clk_i) begin
        pad_o <= pad_level_i;
    end
endmodule

/* verif/pfmux_top_test.sv */
`timescale 1ns/1ps
module pfmux_top_test
    import pfmux_pkg::*;
;
    logic clk_i, rst_i, cyc, stb, we, ack, alt_inv;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [511:0] alt_out, alt_oe;
    logic [127:0] pad_in, pad_out, pad_oe, slew_fast, in_gpio, in_only, pad_level;
    logic [7:0] sel_in;
    logic [1:0] m_alt [PFMUX_NUM_PADS];
    logic m_inbuf [PFMUX_NUM_PADS];
    logic m_slew [PFMUX_NUM_PADS];
    logic [3:0] m_src [PFMUX_NUM_SEL_IN];
    int fail_count, compares, cycles;

    pfmux_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .alt_out_i(alt_out), .alt_oe_i(alt_oe), .pad_in_i(pad_in), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .pad_slew_fast_o(slew_fast), .pad_in_gpio_o(in_gpio),
        .pad_in_only_o(in_only), .sel_in_o(sel_in));
    pfmux_periph_model i_model (.clk_i(clk_i), .alt_inv_i(alt_inv), .pad_level_i(pad_level),
        .alt_out_o(alt_out), .alt_oe_o(alt_oe), .pad_o(pad_in));

    always #4 clk_i = ~clk_i;

    task complete_run;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a stuck loop ends here rather than running forever; a hung bus is cut off by the 40-cycle limit in wb_xfer
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task check(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task wb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        check(128'(n < 40), 128'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task cfg_wr(input int p, input logic [1:0] alt, input logic inbuf, input logic slew, input logic [3:0] s);
        wb_xfer(1'b1, PFMUX_CFG_BASE + 12'(4*p), {23'h0, slew, 3'h0, inbuf, 2'h0, alt}, s);
        if (s[0]) begin
            m_alt[p] = alt;
            m_inbuf[p] = inbuf;
        end
        if (s[1]) m_slew[p] = slew;
    endtask

    task cfg_chk(input int p);
        wb_xfer(1'b0, PFMUX_CFG_BASE + 12'(4*p), 32'h0, 4'hf);
        check(128'(q), 128'({m_slew[p], 3'h0, m_inbuf[p], 2'h0, m_alt[p]}));
    endtask

    task model_clear;
        for (int p = 0; p < PFMUX_NUM_PADS; p++) begin
            m_alt[p] = 2'h0;
            m_inbuf[p] = 1'b0;
            m_slew[p] = 1'b0;
        end
        for (int k = 0; k < PFMUX_NUM_SEL_IN; k++) m_src[k] = 4'h0;
    endtask

    // outputs lag the register or pad change by one cycle, the model adds one more
    task pads_chk;
        logic [127:0] e_oe, e_out, e_slew, e_inbuf;
        logic [7:0] e_sel;
        repeat (3) @(posedge clk_i);
        for (int p = 0; p < PFMUX_NUM_PADS; p++) begin
            e_oe[p] = m_alt[p][1] ^ alt_inv;
            e_out[p] = m_alt[p][0] ^ alt_inv;
            e_slew[p] = m_slew[p];
            e_inbuf[p] = m_inbuf[p];
        end
        for (int k = 0; k < PFMUX_NUM_SEL_IN; k++) e_sel[k] = pad_level[16*k + int'(m_src[k])];
        check(pad_oe, e_oe);
        check(pad_out & e_oe, e_out & e_oe);
        check(slew_fast, e_slew);
        check(in_only, pad_level & e_inbuf);
        check(in_gpio, pad_level);
        check(128'(sel_in), 128'(e_sel));
    endtask

    task end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, we, alt_inv} = 4'h0;
        adr = 12'h0;
        sel = 4'h0;
        wdat = 32'h0;
        pad_level = 128'h0;
        model_clear();
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < PFMUX_NUM_PADS; p += 37) cfg_chk(p);
        pads_chk();
        alt_inv <= 1'b1;
        pads_chk();
        end_test("reset");
        for (int p = 0; p < PFMUX_NUM_PORTS; p++) cfg_wr(16*p + 15 - p, 2'(p), 1'b0, 1'b0, 4'h1);
        for (int p = 0; p < PFMUX_NUM_PORTS; p++) cfg_chk(16*p + 15 - p);
        pads_chk();
        alt_inv <= 1'b0;
        pads_chk();
        end_test("alternates");
        pad_level <= 128'h5a3c_96f0_0ff0_c3a5_e187_7e81_1234_fedc;
        cfg_wr(3, 2'h0, 1'b1, 1'b0, 4'h1);
        cfg_wr(30, 2'h3, 1'b1, 1'b0, 4'h1);
        pads_chk();
        pad_level <= ~pad_level;
        pads_chk();
        end_test("input buffer");
        // slew needs the second byte lane; a low-lane write must leave it slow
        cfg_wr(40, 2'h2, 1'b0, 1'b1, 4'h1);
        pads_chk();
        cfg_wr(40, 2'h0, 1'b0, 1'b1, 4'h2);
        pads_chk();
        cfg_chk(40);
        cfg_wr(40, 2'h2, 1'b0, 1'b0, 4'h3);
        pads_chk();
        end_test("slew");
        for (int k = 0; k < PFMUX_NUM_SEL_IN; k++) begin
            m_src[k] = 4'(k*5 + 3);
            wb_xfer(1'b1, PFMUX_PSM_BASE + 12'(4*k), {28'h0, m_src[k]}, 4'h1);
        end
        pads_chk();
        pad_level <= ~pad_level;
        pads_chk();
        end_test("source select");
        wb_xfer(1'b1, 12'h3fc, 32'hffff_ffff, 4'hf);
        wb_xfer(1'b0, 12'h3fc, 32'h0, 4'hf);
        check(128'(q), 128'h0);
        end_test("unmapped");
        @(posedge clk_i);
        rst_i <= 1'b1;
        alt_inv <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        model_clear();
        cfg_chk(40);
        pads_chk();
        // the write count restarts at reset, so a config write and a source-select write read back as two
        cfg_wr(45, 2'h1, 1'b0, 1'b0, 4'h1);
        wb_xfer(1'b1, PFMUX_PSM_BASE, 32'h0, 4'h1);
        wb_xfer(1'b0, PFMUX_STATUS_ADDR, 32'h0, 4'hf);
        check(128'(q), 128'h2);
        wb_xfer(1'b0, PFMUX_PADIN_BASE + 12'h008, 32'h0, 4'hf);
        check(128'(q), 128'(pad_level[47:32]));
        cfg_chk(45);
        end_test("second reset");
        complete_run();
    end
endmodule
